// ===== common/ats_pkg.sv
// shared constants and types for the auto transmit and print gate
`default_nettype none
package ats_pkg;
   // system clock rate
   localparam int CLK_KHZ      = 50000;
   localparam int CLK_PER_NS   = 20;
   // qualification times as printed
   localparam int START_US     = 5000;   // space time that keys transmit
   localparam int BREAK_MS     = 500;    // held break drops transmit
   localparam int IDENT_MS     = 1000;   // hang after last ident closure
   localparam int HOLD_MS_DFLT = 5000;   // mark hold, adjustable 1 s to 10 s
   localparam int HOLD_MS_MIN  = 1000;
   localparam int HOLD_MS_MAX  = 10000;
   localparam int HYST_NS      = 400;    // slicer settle time with hysteresis
   // derived cycle counts
   localparam int START_CYC    = (START_US * CLK_KHZ + 999) / 1000;
   localparam int BREAK_CYC    = BREAK_MS * CLK_KHZ;
   localparam int IDENT_CYC    = IDENT_MS * CLK_KHZ;
   localparam int HYST_CYC     = (HYST_NS + CLK_PER_NS - 1) / CLK_PER_NS;
   // widths
   localparam int TMR_W        = 30;
   localparam int HYST_W       = 8;
   localparam int PIN_W        = 7;
   localparam int SYNC_LAT     = 4;      // pin edge to synchroniser output, in edges
   // pin vector positions
   localparam int PIN_LOOP     = 0;
   localparam int PIN_KBD      = 1;
   localparam int PIN_RS       = 2;
   localparam int PIN_MIL      = 3;
   localparam int PIN_IDENT    = 4;
   localparam int PIN_HOLD_B   = 5;
   localparam int PIN_DISC     = 6;
   // loop wiring option codes
   localparam logic [1:0] WIRE_SHARED = 2'h0;
   localparam logic [1:0] WIRE_KBD    = 2'h1;
   localparam logic [1:0] WIRE_SERIAL = 2'h2;
   // transmit / receive state, one-hot
   typedef enum logic [1:0] {
      ATS_RX = 2'h1,
      ATS_TX = 2'h2
   } ats_state_e;
   // panel configuration
   typedef struct packed {
      logic       auto_transmit_switch;
      logic       print_local;
      logic       polarity_reverse;
      logic       slicer_hysteresis;
      logic [1:0] loop_wiring_option;
   } ats_cfg_s;
endpackage : ats_pkg
`default_nettype wire

// ===== design/ats_pin_sync.sv
// three-stage input synchroniser with agreement filter
`default_nettype none
module ats_pin_sync #(
   parameter int W = 1
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_b,
   input  wire logic         clk_en,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] pin_out
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         // shift chain, output moves only when stages two and three agree
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               s1_q[g]    <= 1'b0;
               s2_q[g]    <= 1'b0;
               s3_q[g]    <= 1'b0;
               pin_out[g] <= 1'b0;
            end else if (clk_en) begin
               s1_q[g] <= pin_in[g];
               s2_q[g] <= s1_q[g];
               s3_q[g] <= s2_q[g];
               if (s2_q[g] == s3_q[g]) begin
                  pin_out[g] <= s3_q[g];
               end
            end
         end
      end
   endgenerate
endmodule : ats_pin_sync
`default_nettype wire

// ===== design/ats_slicer.sv
// mark/space slicer with optional hysteresis
`default_nettype none
module ats_slicer (
   input  wire logic ref_clk,
   input  wire logic rst_b,
   input  wire logic clk_en,
   input  wire logic hyst_en,
   input  wire logic level_space,
   output logic      slice_space
);
   logic [ats_pkg::HYST_W-1:0] run_q;

   // with hysteresis a new state must persist before the slicer flips
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         run_q       <= '0;
         slice_space <= 1'b0;
      end else if (clk_en) begin
         if (level_space == slice_space) begin
            run_q <= '0;
         end else if (!hyst_en ||
                      run_q == ats_pkg::HYST_W'(ats_pkg::HYST_CYC - 1)) begin
            slice_space <= level_space;
            run_q       <= '0;
         end else begin
            run_q <= run_q + 1'b1;
         end
      end
   end

   chk_slice_settle: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (clk_en && hyst_en && $changed(slice_space)) |->
         $past(level_space, 2) == slice_space)
      else $error("slicer flipped without a settled level");
endmodule : ats_slicer
`default_nettype wire

// ===== design/ats_auto_transmit_gate.sv
// keyboard operated transmit switch and received data print gate
// Behaviour
// - loop space over 5 ms keys transmit
// - ident key closed forces and holds transmit
// - space over half second drops transmit
// - mark beyond hold time drops transmit
// - idle mark drop held off until one second after last ident closure
// - own received openings never key transmit
// - keying output sinks while transmitting
// - transmit holds loop keyer in mark
// - line setting passes received data
// - local setting holds loop keyer mark
// - grounded remote hold acts as local
// - pre-autostart output ignores print gating
// - reverse swaps sense both directions
// - hysteresis needs definite change to switch
// - panel switch off disables auto transmit
// - trigger from shared, keyboard or serial
`default_nettype none
module ats_auto_transmit_gate #(
   parameter int START_CYC = ats_pkg::START_CYC,
   parameter int BREAK_CYC = ats_pkg::BREAK_CYC,
   parameter int IDENT_CYC = ats_pkg::IDENT_CYC,
   parameter int HOLD_CYC  = ats_pkg::HOLD_MS_DFLT * ats_pkg::CLK_KHZ
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   input  wire logic             clk_en,
   input  wire ats_pkg::ats_cfg_s cfg,
   input  wire logic             loop_space,
   input  wire logic             kbd_space,
   input  wire logic             serial_rs_space,
   input  wire logic             serial_mil_space,
   input  wire logic             morse_ident_key,
   input  wire logic             remote_hold_b,
   input  wire logic             disc_high_tone,
   output logic                  ptt_sink,
   output logic                  tx_active,
   output logic                  keyer_space,
   output logic                  pre_data_space,
   output logic                  tone_high
);
   ////////////////////////////////////////////////////////////////////////
   // input conditioning

   logic [ats_pkg::PIN_W-1:0] pin_raw;
   logic [ats_pkg::PIN_W-1:0] pin_s;
   logic                      disc_space;
   logic                      rx_space;

   // pin vector order follows the package positions
   assign pin_raw = {disc_high_tone, remote_hold_b, morse_ident_key,
                     serial_mil_space, serial_rs_space, kbd_space, loop_space};

   ats_pin_sync #(
      .W       (ats_pkg::PIN_W)
   ) u_sync (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .clk_en  (clk_en),
      .pin_in  (pin_raw),
      .pin_out (pin_s)
   );

   // normal sense is mark on the lower tone, reverse swaps it
   assign disc_space = pin_s[ats_pkg::PIN_DISC] ^ cfg.polarity_reverse;

   ats_slicer u_slicer (
      .ref_clk     (ref_clk),
      .rst_b       (rst_b),
      .clk_en      (clk_en),
      .hyst_en     (cfg.slicer_hysteresis),
      .level_space (disc_space),
      .slice_space (rx_space)
   );

   ////////////////////////////////////////////////////////////////////////
   // transmit trigger source

   // picks the space indication that counts as operator typing
   function automatic logic trig_pick(input logic [1:0]               opt,
                                      input logic [ats_pkg::PIN_W-1:0] p,
                                      input logic                      own_space);
      logic r;
      r = 1'b0;
      case (opt)
         ats_pkg::WIRE_KBD:    r = p[ats_pkg::PIN_KBD];
         ats_pkg::WIRE_SERIAL: r = p[ats_pkg::PIN_RS] | p[ats_pkg::PIN_MIL];
         default:              r = p[ats_pkg::PIN_LOOP] & ~own_space;
      endcase
      return r;
   endfunction : trig_pick

   logic trig_space;
   logic ident_s;
   logic hold_s;
   logic auto_en;
   logic [ats_pkg::SYNC_LAT-1:0] own_hist_q;
   logic                         own_span;

   // recent keyer history, covers our own spacing still inside the synchroniser
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         own_hist_q <= '0;
      end else if (clk_en) begin
         own_hist_q <= {own_hist_q[ats_pkg::SYNC_LAT-2:0], keyer_space};
      end
   end

   assign own_span = keyer_space || (own_hist_q != '0);

   // shared loop openings while our keyer spaces are our own data
   assign trig_space = trig_pick(cfg.loop_wiring_option, pin_s, own_span);
   assign ident_s    = pin_s[ats_pkg::PIN_IDENT];
   assign hold_s     = ~pin_s[ats_pkg::PIN_HOLD_B];
   assign auto_en    = cfg.auto_transmit_switch;

   ////////////////////////////////////////////////////////////////////////
   // qualification timers

   logic [ats_pkg::TMR_W-1:0] space_cnt_q;
   logic [ats_pkg::TMR_W-1:0] mark_cnt_q;
   logic [ats_pkg::TMR_W-1:0] ident_cnt_q;
   logic                      break_lock_q;
   logic                      start_hit;
   logic                      break_hit;
   logic                      hold_hit;
   logic                      ident_hang;

   assign start_hit  = trig_space && !break_lock_q &&
                       space_cnt_q >= ats_pkg::TMR_W'(START_CYC - 1);
   assign break_hit  = trig_space && space_cnt_q >= ats_pkg::TMR_W'(BREAK_CYC - 1);
   assign hold_hit   = !trig_space && mark_cnt_q >= ats_pkg::TMR_W'(HOLD_CYC - 1);
   assign ident_hang = ident_s || ident_cnt_q != '0;

   // continuous space run, saturating
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         space_cnt_q <= '0;
      end else if (clk_en) begin
         if (!trig_space || !auto_en) begin
            space_cnt_q <= '0;
         end else if (space_cnt_q != {ats_pkg::TMR_W{1'b1}}) begin
            space_cnt_q <= space_cnt_q + 1'b1;
         end
      end
   end

   // continuous mark run while transmitting
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         mark_cnt_q <= '0;
      end else if (clk_en) begin
         if (trig_space || tx_active == 1'b0 || !auto_en) begin
            mark_cnt_q <= '0;
         end else if (mark_cnt_q != {ats_pkg::TMR_W{1'b1}}) begin
            mark_cnt_q <= mark_cnt_q + 1'b1;
         end
      end
   end

   // hang timer reloads on every ident closure while the panel switch is on
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ident_cnt_q <= '0;
      end else if (clk_en) begin
         if (ident_s && auto_en) begin
            ident_cnt_q <= ats_pkg::TMR_W'(IDENT_CYC);
         end else if (ident_cnt_q != '0) begin
            ident_cnt_q <= ident_cnt_q - 1'b1;
         end
      end
   end

   // after a break drop outside the ident hang, a new start needs the loop back in mark first
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         break_lock_q <= 1'b0;
      end else if (clk_en) begin
         if (!trig_space) begin
            break_lock_q <= 1'b0;
         end else if (tx_active && break_hit && !ident_hang) begin
            break_lock_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transmit / receive state

   ats_pkg::ats_state_e state_q;
   ats_pkg::ats_state_e state_d;

   // enter on typing or ident, leave on break, or on idle mark once the ident hang has ended
   always_comb begin
      state_d = state_q;
      case (state_q)
         ats_pkg::ATS_RX: begin
            if (auto_en && (ident_s || start_hit)) begin
               state_d = ats_pkg::ATS_TX;
            end
         end
         ats_pkg::ATS_TX: begin
            if (ident_s) begin
               state_d = ats_pkg::ATS_TX;
            end else if (break_hit) begin
               state_d = ats_pkg::ATS_RX;
            end else if (hold_hit && ident_cnt_q == '0) begin
               state_d = ats_pkg::ATS_RX;
            end
         end
         default: state_d = ats_pkg::ATS_RX;
      endcase
      if (!auto_en) begin
         state_d = ats_pkg::ATS_RX;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ats_pkg::ATS_RX;
      end else if (clk_en) begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   logic tx_d;
   assign tx_d = (state_d == ats_pkg::ATS_TX);

   // keying transistor follows the next state
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ptt_sink  <= 1'b0;
         tx_active <= 1'b0;
      end else if (clk_en) begin
         ptt_sink  <= tx_d;
         tx_active <= tx_d;
      end
   end

   // post-autostart keyer held mark by transmit, local or remote hold
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         keyer_space <= 1'b0;
      end else if (clk_en) begin
         if (tx_d || cfg.print_local || hold_s) begin
            keyer_space <= 1'b0;
         end else begin
            keyer_space <= rx_space;
         end
      end
   end

   // pre-autostart data never sees the print gate
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pre_data_space <= 1'b0;
      end else if (clk_en) begin
         pre_data_space <= rx_space;
      end
   end

   // tone keyer select, space is the high tone unless reversed
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         tone_high <= 1'b0;
      end else if (clk_en) begin
         tone_high <= trig_space ^ cfg.polarity_reverse;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   sequence s_ident_release;
      clk_en && auto_en && ident_s ##1 (clk_en && auto_en && !ident_s && !break_hit)[*2];
   endsequence

   chk_ident_keys: assert property (
      clk_en && auto_en && ident_s |=> ptt_sink && tx_active)
      else $error("ident closure did not key transmit");

   chk_ident_hang: assert property (
      s_ident_release |-> ptt_sink)
      else $error("transmit dropped right after ident release");

   chk_start_time: assert property (
      clk_en && auto_en && state_q == ats_pkg::ATS_RX && trig_space &&
      !break_lock_q && space_cnt_q == ats_pkg::TMR_W'(START_CYC - 1) |=> ptt_sink)
      else $error("transmit not keyed after start time");

   chk_early_none: assert property (
      clk_en && state_q == ats_pkg::ATS_RX && !ident_s &&
      space_cnt_q < ats_pkg::TMR_W'(START_CYC - 1) |=> !ptt_sink)
      else $error("transmit keyed before start time");

   chk_break_drop: assert property (
      clk_en && auto_en && state_q == ats_pkg::ATS_TX && !ident_s && trig_space &&
      space_cnt_q == ats_pkg::TMR_W'(BREAK_CYC - 1) |=> !ptt_sink)
      else $error("held break did not drop transmit");

   chk_hold_drop: assert property (
      clk_en && state_q == ats_pkg::ATS_TX && !ident_s && !trig_space &&
      ident_cnt_q == '0 && mark_cnt_q == ats_pkg::TMR_W'(HOLD_CYC - 1) |=> !ptt_sink)
      else $error("idle mark did not drop transmit");

   chk_keyer_gate: assert property (
      clk_en && (tx_d || cfg.print_local || hold_s) |=> !keyer_space)
      else $error("loop keyer spaced while gated");

   chk_line_pass: assert property (
      clk_en && !tx_d && !cfg.print_local && !hold_s |=> keyer_space == $past(rx_space))
      else $error("line setting did not pass received data");

   chk_pre_free: assert property (
      clk_en |=> pre_data_space == $past(rx_space))
      else $error("pre-autostart output not ungated");

   chk_panel_off: assert property (
      clk_en && !auto_en |=> !ptt_sink ##0 mark_cnt_q == '0)
      else $error("transmit active with panel switch off");

   chk_own_data: assert property (
      clk_en && cfg.loop_wiring_option == ats_pkg::WIRE_SHARED && $fell(keyer_space) |->
         (!trig_space)[*4])
      else $error("own received opening taken as typing");

   chk_tone_sense: assert property (
      clk_en |=> tone_high == ($past(trig_space) ^ $past(cfg.polarity_reverse)))
      else $error("tone select sense wrong");

   chk_ident_block: assert property (
      clk_en && auto_en && state_q == ats_pkg::ATS_TX && !break_hit &&
      ident_cnt_q != '0 |=> ptt_sink)
      else $error("transmit dropped during ident hang");
endmodule : ats_auto_transmit_gate
`default_nettype wire

// ===== tb/ats_far_side.sv
// far side model: shared teleprinter loop and keyboard contacts
`default_nettype none
module ats_far_side (
   input  wire logic keyer_space,
   input  wire logic kbd_open,
   input  wire logic sep_kbd,
   output logic      loop_space,
   output logic      kbd_space
);
   timeunit 1ns;
   timeprecision 1ns;
   // series loop opens for our keyer or for a shared keyboard
   assign loop_space = keyer_space | (kbd_open & !sep_kbd);
   // separate keyboard loop idles closed, mark
   assign kbd_space = kbd_open & sep_kbd;
endmodule : ats_far_side
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the auto transmit and print gate
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic              ref_clk;
   logic              rst_b;
   logic              clk_en;
   ats_pkg::ats_cfg_s cfg;
   logic              kbd_open;
   logic              sep_kbd;
   logic              rs_sp;
   logic              mil_sp;
   logic              ident;
   logic              hold_b;
   logic              disc;
   logic              loop_space;
   logic              kbd_space;
   logic              ptt_sink;
   logic              tx_active;
   logic              keyer_space;
   logic              pre_data_space;
   logic              tone_high;
   int                n_mismatch;
   int                cmp_count;

   ////////////////////////////////////////////////////////////////////
   // design with shortened timers, and the loop model
   ats_auto_transmit_gate #(
      .START_CYC (10),
      .BREAK_CYC (100),
      .IDENT_CYC (60),
      .HOLD_CYC  (40)
   ) u_dut (
      .ref_clk          (ref_clk),
      .rst_b            (rst_b),
      .clk_en           (clk_en),
      .cfg              (cfg),
      .loop_space       (loop_space),
      .kbd_space        (kbd_space),
      .serial_rs_space  (rs_sp),
      .serial_mil_space (mil_sp),
      .morse_ident_key  (ident),
      .remote_hold_b    (hold_b),
      .disc_high_tone   (disc),
      .ptt_sink         (ptt_sink),
      .tx_active        (tx_active),
      .keyer_space      (keyer_space),
      .pre_data_space   (pre_data_space),
      .tone_high        (tone_high)
   );

   ats_far_side u_far (
      .keyer_space (keyer_space),
      .kbd_open    (kbd_open),
      .sep_kbd     (sep_kbd),
      .loop_space  (loop_space),
      .kbd_space   (kbd_space)
   );

   ////////////////////////////////////////////////////////////////////
   // shared tasks: step past edges, compare, finish
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask : tick

   task automatic chk(input string what, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %b seen %b at %0t", what, exp, got, $time);
      end
   endtask : chk

   task automatic summarize();
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize

   // clock, 20 ns period
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // watchdog against a hang
   initial begin
      repeat (5000) @(posedge ref_clk);
      n_mismatch++;
      summarize();
   end

   ////////////////////////////////////////////////////////////////////
   // test sequence
   initial begin
      n_mismatch = 0;
      cmp_count  = 0;
      rst_b      = 1'b0;
      clk_en     = 1'b1;
      cfg        = '{1'b1, 1'b0, 1'b0, 1'b0, ats_pkg::WIRE_SHARED};
      kbd_open   = 1'b0;
      sep_kbd    = 1'b0;
      rs_sp      = 1'b0;
      mil_sp     = 1'b0;
      ident      = 1'b0;
      hold_b     = 1'b1;
      disc       = 1'b0;
      repeat (5) @(posedge ref_clk);
      #2;
      rst_b = 1'b1;
      chk("ptt_sink", 1'b0, ptt_sink);
      chk("keyer_space", 1'b0, keyer_space);
      tick(10);
      chk("tone_high", 1'b0, tone_high);
      // short opening stays in receive
      kbd_open = 1'b1;
      tick(5);
      kbd_open = 1'b0;
      tick(20);
      chk("ptt_sink", 1'b0, ptt_sink);
      // opening past start time keys, held break drops
      kbd_open = 1'b1;
      tick(20);
      chk("ptt_sink", 1'b1, ptt_sink);
      chk("tx_active", 1'b1, tx_active);
      tick(60);
      chk("ptt_sink", 1'b1, ptt_sink);
      tick(40);
      chk("ptt_sink", 1'b0, ptt_sink);
      kbd_open = 1'b0;
      tick(30);
      // typing then pausing past the mark hold
      kbd_open = 1'b1;
      tick(20);
      kbd_open = 1'b0;
      tick(30);
      chk("ptt_sink", 1'b1, ptt_sink);
      tick(30);
      chk("ptt_sink", 1'b0, ptt_sink);
      // ident key holds transmit, keyer held mark
      ident = 1'b1;
      tick(10);
      chk("ptt_sink", 1'b1, ptt_sink);
      disc = 1'b1;
      tick(10);
      chk("keyer_space", 1'b0, keyer_space);
      chk("pre_data_space", 1'b1, pre_data_space);
      tick(100);
      chk("ptt_sink", 1'b1, ptt_sink);
      ident = 1'b0;
      disc  = 1'b0;
      tick(50);
      chk("ptt_sink", 1'b1, ptt_sink);
      tick(30);
      chk("ptt_sink", 1'b0, ptt_sink);
      // line passes data; own openings never key
      disc = 1'b1;
      tick(10);
      chk("keyer_space", 1'b1, keyer_space);
      tick(30);
      chk("ptt_sink", 1'b0, ptt_sink);
      cfg.print_local = 1'b1;
      tick(4);
      chk("keyer_space", 1'b0, keyer_space);
      chk("pre_data_space", 1'b1, pre_data_space);
      cfg.print_local = 1'b0;
      hold_b = 1'b0;
      tick(10);
      chk("keyer_space", 1'b0, keyer_space);
      hold_b = 1'b1;
      tick(10);
      chk("keyer_space", 1'b1, keyer_space);
      disc = 1'b0;
      tick(10);
      chk("keyer_space", 1'b0, keyer_space);
      // reversed sense in both directions
      cfg.polarity_reverse = 1'b1;
      tick(10);
      chk("pre_data_space", 1'b1, pre_data_space);
      chk("tone_high", 1'b1, tone_high);
      disc = 1'b1;
      tick(10);
      chk("pre_data_space", 1'b0, pre_data_space);
      disc = 1'b0;
      cfg.polarity_reverse = 1'b0;
      tick(20);
      // hysteresis rejects a brief change
      cfg.slicer_hysteresis = 1'b1;
      tick(10);
      disc = 1'b1;
      tick(6);
      disc = 1'b0;
      tick(40);
      chk("pre_data_space", 1'b0, pre_data_space);
      disc = 1'b1;
      tick(40);
      chk("pre_data_space", 1'b1, pre_data_space);
      disc = 1'b0;
      tick(40);
      cfg.slicer_hysteresis = 1'b0;
      // clock enable low freezes the whole receive path
      clk_en = 1'b0;
      disc   = 1'b1;
      tick(20);
      chk("pre_data_space", 1'b0, pre_data_space);
      clk_en = 1'b1;
      tick(10);
      chk("pre_data_space", 1'b1, pre_data_space);
      disc = 1'b0;
      tick(10);
      // panel switch off disables keying
      cfg.auto_transmit_switch = 1'b0;
      kbd_open = 1'b1;
      tick(30);
      chk("ptt_sink", 1'b0, ptt_sink);
      kbd_open = 1'b0;
      tick(10);
      cfg.auto_transmit_switch = 1'b1;
      tick(20);
      // separate keyboard and both serial inputs as trigger
      for (int i = 0; i < 3; i++) begin
         cfg.loop_wiring_option = (i == 0) ? ats_pkg::WIRE_KBD : ats_pkg::WIRE_SERIAL;
         sep_kbd = (i == 0);
         tick(5);
         kbd_open = (i == 0);
         rs_sp = (i == 1);
         mil_sp = (i == 2);
         tick(20);
         chk("ptt_sink", 1'b1, ptt_sink);
         kbd_open = 1'b0;
         rs_sp = 1'b0;
         mil_sp = 1'b0;
         tick(80);
         chk("ptt_sink", 1'b0, ptt_sink);
      end
      summarize();
   end
endmodule : tb_top
`default_nettype wire
